// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "txvf_defines.svh"
module tb;
    import txvf_pkg::*;
    logic        clk = 1'b0, srst = 1'b1, write_ref_clock, write_strobe;
    logic        write_pointer_reset = 1'b0, bank_poll_disable = 1'b0, rd_req = 1'b0;
    logic [2:0]  rd_part = 3'h0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, irq, partition_full_flag, rd_valid;
    txvf_wr_t    wr_in;
    txvf_entry_t rd_entry, exp_q[8][$];
    int          miscompares = 0, check_count = 0;
    txvf_user user (.clk, .write_ref_clock, .wr_in, .write_strobe);
    txvf_port DUT (.clk, .srst, .write_ref_clock, .wr_in, .write_strobe, .write_pointer_reset,
        .bank_poll_disable, .rd_req, .rd_part, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .irq, .partition_full_flag, .rd_valid, .rd_entry);
    always #10 clk = ~clk;
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        check_count++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask : chk
    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
    endtask : ticks
    task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        ticks(1);
        reg_wr <= 1'b0;
        ticks(1);
    endtask : reg_write
    task automatic reg_chk(input string n, input logic [3:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        ticks(1);
        reg_rd <= 1'b0;
        ticks(1);
        chk(n, e, reg_rdata);
    endtask : reg_chk
    task automatic line(input logic [2:0] p, input int n, input logic [3:0] m, input logic er,
                        input bit keep);
        txvf_wr_t w;
        for (int i = 0; i < n; i++) begin
            w.part = p;
            w.word = {16'h5a3c, 5'h00, p, i[7:0]};
            w.mask = (i == n - 1) ? m : `TXVF_MASK_ALL;
            w.sop = (i == 0);
            w.eop = (i == n - 1);
            w.err = er && w.eop;
            w.port = {5'h08, p};
            user.send(w, 1'b1);
            if (keep && w.mask != `TXVF_MASK_NONE) begin
                exp_q[p].push_back('{w.word, w.mask, w.sop, w.eop, w.err, w.port});
            end
        end
    endtask : line
    task automatic poll(input logic [2:0] p, input logic e);
        txvf_wr_t w;
        w = '0;
        w.part = p;
        user.send(w, 1'b0);
        ticks(4);
        chk("full flag", e, partition_full_flag);
    endtask : poll
    task automatic drain(input logic [2:0] p, input bit open);
        rd_part <= p;
        rd_req <= 1'b1;
        repeat (60) begin
            @(posedge clk);
            if (rd_valid === 1'b1) begin
                if (!open || exp_q[p].size() == 0) chk("extra word", 64'h0, 64'h1);
                else chk("drained entry", exp_q[p].pop_front(), rd_entry);
            end
        end
        rd_req <= 1'b0;
        @(posedge clk);
        if (open) chk("words left", 64'h0, exp_q[p].size());
    endtask : drain
    task automatic t_lines;
        line(3'h1, 4, `TXVF_MASK_ALL, 1'b0, 1'b1);
        line(3'h1, 3, `TXVF_MASK_THREE, 1'b1, 1'b1);
        line(3'h2, 1, `TXVF_MASK_ONE, 1'b0, 1'b1);
        drain(3'h1, 1'b1);
        drain(3'h2, 1'b1);
    endtask : t_lines
    task automatic t_irq;
        reg_write(`TXVF_REG_IRQ_CLR, 32'h7); // full event left over from t_fill
        reg_write(`TXVF_REG_IRQ_EN, 32'h7);
        line(3'h3, 1, `TXVF_MASK_NONE, 1'b0, 1'b1);
        line(3'h3, 1, 4'h3, 1'b0, 1'b1);
        reg_chk("status", `TXVF_REG_IRQ_STAT, 32'h5);
        chk("irq raised", 1'b1, irq);
        reg_write(`TXVF_REG_IRQ_EN, 32'h0);
        ticks(2);
        chk("irq masked", 1'b0, irq);
        reg_write(`TXVF_REG_IRQ_CLR, 32'h7);
        reg_write(`TXVF_REG_IRQ_EN, 32'h7);
        reg_chk("status cleared", `TXVF_REG_IRQ_STAT, 32'h0);
        chk("irq cleared", 1'b0, irq);
        drain(3'h3, 1'b1);
    endtask : t_irq
    task automatic t_disable_reset;
        bank_poll_disable <= 1'b1;
        line(3'h4, 1, `TXVF_MASK_ONE, 1'b0, 1'b1);
        reg_chk("bank disable", `TXVF_REG_BANK, 32'h1);
        drain(3'h4, 1'b0);
        bank_poll_disable <= 1'b0;
        drain(3'h4, 1'b1);
        line(3'h5, 2, `TXVF_MASK_ALL, 1'b0, 1'b1);
        write_pointer_reset <= 1'b1;
        ticks(12);
        write_pointer_reset <= 1'b0;
        exp_q[5].delete();
        drain(3'h5, 1'b1);
    endtask : t_disable_reset
    task automatic t_fill;
        chk("idle outputs", 64'h0, {irq, partition_full_flag, rd_valid, reg_rdata});
        reg_chk("fill level", `TXVF_REG_FILL_LVL, {26'h0, `TXVF_FILL_LEVEL});
        reg_chk("unmapped", 4'hf, 32'h0);
        reg_write(`TXVF_REG_FILL_LVL, 32'h2);
        repeat (2) line(3'h6, 1, `TXVF_MASK_ONE, 1'b0, 1'b1);
        poll(3'h6, 1'b0);
        line(3'h6, 1, `TXVF_MASK_ONE, 1'b0, 1'b1);
        poll(3'h6, 1'b1);
        line(3'h6, 1, `TXVF_MASK_ONE, 1'b0, 1'b0);
        poll(3'h7, 1'b0);
        drain(3'h6, 1'b1);
    endtask : t_fill
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    initial begin
        ticks(20);
        srst <= 1'b0;
        ticks(4);
        t_fill;
        reg_write(`TXVF_REG_FILL_LVL, {26'h0, `TXVF_FILL_LEVEL});
        t_lines;
        t_irq;
        t_disable_reset;
        finish_test;
    end
endmodule : tb
`default_nettype wire

// ### txvf_defines.svh
`ifndef TXVF_DEFINES_SVH
`define TXVF_DEFINES_SVH

`define TXVF_PARTS        8
`define TXVF_PART_W       3
`define TXVF_LINE_W       5
`define TXVF_LINES        32
`define TXVF_LANES        4
`define TXVF_LANE_W       2
`define TXVF_FILL_W       6
`define TXVF_FILL_LEVEL   6'h1c
`define TXVF_PTR_ZERO     5'h00
`define TXVF_LANE_ZERO    2'h0
`define TXVF_LANE_LAST    2'h3
`define TXVF_LANE_ONE     2'h1
`define TXVF_LINE_ONE     5'h01
`define TXVF_FILL_ZERO    6'h00
`define TXVF_FILL_ONE     6'h01
`define TXVF_MASK_NONE    4'h0
`define TXVF_MASK_ALL     4'hf
`define TXVF_MASK_THREE   4'he
`define TXVF_MASK_ONE     4'h8
`define TXVF_IDLE_WORD    32'h0000_0000
`define TXVF_IRQ_BAD_MASK 0
`define TXVF_IRQ_FULL     1
`define TXVF_IRQ_DROP     2
`define TXVF_IRQ_W        3
`define TXVF_REG_IRQ_STAT 4'h0
`define TXVF_REG_IRQ_CLR  4'h1
`define TXVF_REG_IRQ_EN   4'h2
`define TXVF_REG_FILL_LVL 4'h3
`define TXVF_REG_BANK     4'h4

`endif

// ### txvf_pkg.sv
package txvf_pkg;
    typedef struct packed {
        logic [2:0]  part;
        logic [31:0] word;
        logic [3:0]  mask;
        logic        sop;
        logic        eop;
        logic        err;
        logic [7:0]  port;
    } txvf_wr_t;

    typedef struct packed {
        logic [31:0] word;
        logic [3:0]  mask;
        logic        sop;
        logic        eop;
        logic        err;
        logic [7:0]  port;
    } txvf_entry_t;

    typedef enum logic [1:0] {
        TXVF_RD_IDLE = 2'b00,
        TXVF_RD_SEND = 2'b01,
        TXVF_RD_GAP  = 2'b10
    } txvf_rd_state_t;
endpackage : txvf_pkg

// ### txvf_port.sv
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "txvf_defines.svh"
// How it works
// (RL1) end of packet moves pointer to next line
// (RL2) all-zero byte mask writes nothing
// (RL3) bank disable stops polling that memory
// (RL4) pointer reset input clears partition pointer
// (RL5) fill status on every addressed cycle
// (RL6) three-bit address picks one of eight partitions
// (RL7) user writes four words per line
// (RL8) mask bit n covers byte n
// (RL9) user masks all bytes except last
// (RL10) only 1111, 1110, 1000 are valid
// (RL11) user marks start on first line word
// (RL12) end flag may come on any word
// (RL13) user raises error only with end
// (RL14) strobe high captures word and flags
// (RL15) disabled bank sends idle words
// (RL16) full when occupancy crosses fill level
// (RL17) user gives port number with write
// (RL18) write clock independent of other ports
// (RL19) inputs sampled on write clock edge
module txvf_port (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              write_ref_clock,
    input  wire txvf_pkg::txvf_wr_t wr_in,
    input  wire logic              write_strobe,
    input  wire logic              write_pointer_reset,
    input  wire logic              bank_poll_disable,
    input  wire logic              rd_req,
    input  wire logic [2:0]        rd_part,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    output logic                   irq,
    output logic                   partition_full_flag,
    output logic                   rd_valid,
    output txvf_pkg::txvf_entry_t  rd_entry
);
    import txvf_pkg::*;

    // one synchroniser for the whole sampled write bus plus clock
    localparam int SW = $bits(txvf_wr_t) + 4;
    logic [SW-1:0]   sync_q;
    txvf_wr_t        w;
    logic            w_stb;
    logic            w_rst;
    logic            w_dis;
    logic            wclk_q;
    logic            wclk_d;
    logic            wedge;

    // bus is sampled through two flops; the user must hold inputs across
    // a write clock edge plus two system cycles (see RL18)
    txvf_sync #(.W(SW)) u_sync (
        .clk  (clk),
        .srst (srst),
        .d    ({write_ref_clock, write_strobe, write_pointer_reset,
                bank_poll_disable, wr_in}),
        .q    (sync_q)
    );
    assign {wclk_q, w_stb, w_rst, w_dis, w} = sync_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            wclk_d <= 1'b0;
        end else begin
            wclk_d <= wclk_q;
        end
    end
    assign wedge = wclk_q & ~wclk_d; // see RL19

    txvf_entry_t     mem [`TXVF_PARTS][`TXVF_LINES][`TXVF_LANES];
    logic [`TXVF_LINE_W-1:0] wr_line [`TXVF_PARTS];
    logic [`TXVF_LANE_W-1:0] wr_lane [`TXVF_PARTS];
    logic [`TXVF_LINE_W-1:0] rd_line [`TXVF_PARTS];
    logic [`TXVF_LANE_W-1:0] rd_lane [`TXVF_PARTS];
    logic [`TXVF_FILL_W-1:0] fill    [`TXVF_PARTS];
    logic [`TXVF_FILL_W-1:0] fill_level;
    logic [`TXVF_IRQ_W-1:0]  irq_stat;
    logic [`TXVF_IRQ_W-1:0]  irq_en;
    logic [`TXVF_IRQ_W-1:0]  irq_clr;
    logic [`TXVF_IRQ_W-1:0]  irq_set;

    logic [2:0]      p;
    logic            do_wr;
    logic            mask_ok;
    logic            line_end;
    logic            line_has;
    logic [`TXVF_PARTS-1:0] line_used;
    logic            part_full;
    logic            rd_ok;
    logic            rd_line_end;
    logic            bank_poll_disable_q;
    txvf_entry_t     rd_entry_next;

    assign p        = w.part; // see RL6
    assign mask_ok  = (w.mask == `TXVF_MASK_ALL) || (w.mask == `TXVF_MASK_THREE)
                   || (w.mask == `TXVF_MASK_ONE); // see RL10
    assign part_full = fill[p] > fill_level; // see RL16
    // strobe with a non-empty mask stores unless the partition is full; an empty mask is dropped
    assign do_wr    = wedge & w_stb & (w.mask != `TXVF_MASK_NONE)
                    & ~part_full; // see RL2 RL14
    assign line_end = do_wr & (w.eop | (wr_lane[p] == `TXVF_LANE_LAST)); // see RL1 RL12
    // a line that was never written does not count toward occupancy
    assign line_has = line_used[p] | do_wr;
    assign rd_ok    = rd_req & ~bank_poll_disable_q & (fill[rd_part] != `TXVF_FILL_ZERO); // see RL3
    assign rd_line_end = rd_ok & (rd_entry_next.eop | (rd_lane[rd_part] == `TXVF_LANE_LAST));

    assign bank_poll_disable_q = w_dis;

    assign rd_entry_next = mem[rd_part][rd_line[rd_part]][rd_lane[rd_part]];

    // memory write; the whole word is stored with its mask bits beside it (see RL8)
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[p][wr_line[p]][wr_lane[p]] <= '{word: w.word, mask: w.mask,
                sop: w.sop, eop: w.eop, err: w.err & w.eop, port: w.port}; // see RL14 RL17
        end
    end

    // write pointers per partition
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < `TXVF_PARTS; i++) begin
                wr_line[i]   <= `TXVF_PTR_ZERO;
                wr_lane[i]   <= `TXVF_LANE_ZERO;
                line_used[i] <= 1'b0;
            end
        end else if (wedge & w_rst) begin
            wr_line[p]   <= `TXVF_PTR_ZERO; // see RL4
            wr_lane[p]   <= `TXVF_LANE_ZERO;
            line_used[p] <= 1'b0;
        end else if (line_end) begin
            wr_line[p]   <= wr_line[p] + `TXVF_LINE_ONE; // see RL1
            wr_lane[p]   <= `TXVF_LANE_ZERO;
            line_used[p] <= 1'b0;
        end else if (do_wr) begin
            wr_lane[p]   <= wr_lane[p] + `TXVF_LANE_ONE;
            line_used[p] <= 1'b1;
        end
    end

    // read pointers, drained by the arbiter side
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < `TXVF_PARTS; i++) begin
                rd_line[i] <= `TXVF_PTR_ZERO;
                rd_lane[i] <= `TXVF_LANE_ZERO;
            end
        end else begin
            if (rd_line_end) begin
                rd_line[rd_part] <= rd_line[rd_part] + `TXVF_LINE_ONE;
                rd_lane[rd_part] <= `TXVF_LANE_ZERO;
            end else if (rd_ok) begin
                rd_lane[rd_part] <= rd_lane[rd_part] + `TXVF_LANE_ONE;
            end
            // placed last so it wins only for its own partition; a drain
            // of another partition in the same cycle must not be lost
            if (wedge & w_rst) begin
                rd_line[p] <= `TXVF_PTR_ZERO; // see RL4
                rd_lane[p] <= `TXVF_LANE_ZERO;
            end
        end
    end

    // occupancy counted in lines; simultaneous add and drain cancel
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < `TXVF_PARTS; i++) begin
                fill[i] <= `TXVF_FILL_ZERO;
            end
        end else begin
            for (int i = 0; i < `TXVF_PARTS; i++) begin
                if (wedge & w_rst & (p == 3'(i))) begin
                    fill[i] <= `TXVF_FILL_ZERO;
                end else if ((line_end & line_has & (p == 3'(i)))
                             && !(rd_line_end && (rd_part == 3'(i)))) begin
                    fill[i] <= fill[i] + `TXVF_FILL_ONE;
                end else if (!(line_end & line_has & (p == 3'(i)))
                             && rd_line_end && (rd_part == 3'(i))) begin
                    fill[i] <= fill[i] - `TXVF_FILL_ONE;
                end
            end
        end
    end

    // outgoing arbiter data; idle words while the bank is disabled
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_valid <= 1'b0;
            rd_entry <= '0;
        end else if (rd_ok) begin
            rd_valid <= 1'b1;
            rd_entry <= rd_entry_next;
        end else begin
            rd_valid <= 1'b0; // see RL15
            rd_entry <= '{word: `TXVF_IDLE_WORD, default: '0};
        end
    end

    // status answers any addressed cycle, strobe or not
    always_ff @(posedge clk) begin
        if (srst) begin
            partition_full_flag <= 1'b0;
        end else if (wedge) begin
            partition_full_flag <= part_full; // see RL5 RL16
        end
    end

    // interrupt events
    assign irq_set[`TXVF_IRQ_BAD_MASK] = wedge & w_stb & ~mask_ok;
    assign irq_set[`TXVF_IRQ_FULL]     = wedge & w_stb & part_full;
    assign irq_set[`TXVF_IRQ_DROP]     = wedge & w_stb & (w.mask == `TXVF_MASK_NONE);
    assign irq_clr = (reg_wr && reg_addr == `TXVF_REG_IRQ_CLR) ?
                     reg_wdata[`TXVF_IRQ_W-1:0] : '0;

    // set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_en     <= '0;
            fill_level <= `TXVF_FILL_LEVEL;
        end else if (reg_wr && reg_addr == `TXVF_REG_IRQ_EN) begin
            irq_en <= reg_wdata[`TXVF_IRQ_W-1:0];
        end else if (reg_wr && reg_addr == `TXVF_REG_FILL_LVL) begin
            fill_level <= reg_wdata[`TXVF_FILL_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irq_stat & ~irq_clr | irq_set) & irq_en);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                `TXVF_REG_IRQ_STAT: reg_rdata <= {29'h0, irq_stat};
                `TXVF_REG_IRQ_EN:   reg_rdata <= {29'h0, irq_en};
                `TXVF_REG_FILL_LVL: reg_rdata <= {26'h0, fill_level};
                `TXVF_REG_BANK:     reg_rdata <= {31'h0, bank_poll_disable_q};
                default:            reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule : txvf_port
`default_nettype wire

// ### txvf_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
module txvf_port_properties (
    input wire logic                  clk,
    input wire logic                  srst,
    input wire logic                  write_ref_clock,
    input wire logic                  bank_poll_disable,
    input wire logic                  rd_req,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [31:0]           reg_rdata,
    input wire logic                  irq,
    input wire logic                  partition_full_flag,
    input wire logic                  rd_valid,
    input wire txvf_pkg::txvf_entry_t rd_entry
);
    import txvf_pkg::*;
    logic       prev_wrc;
    logic [3:0] since_rise;
    always_ff @(posedge clk) begin
        prev_wrc <= write_ref_clock;
        if (write_ref_clock && !prev_wrc) begin
            since_rise <= 4'h0;
        end else if (since_rise != 4'hf) begin
            since_rise <= since_rise + 4'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // disable passes two sync flops and the output register first
    sequence s_held_disable;
        bank_poll_disable [*4];
    endsequence
    a_reset_drain_quiet: assert property (disable iff (1'b0)
        srst |=> !rd_valid && !partition_full_flag) else $error("drain active after reset");
    a_reset_irq_quiet: assert property (disable iff (1'b0)
        srst |=> !irq && reg_rdata == 32'h0) else $error("irq or data after reset");
    a_rdata_only_read: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data without read");
    a_disable_no_drain: assert property (s_held_disable |-> !rd_valid)
        else $error("drain while bank disabled");
    a_full_on_edge: assert property ($changed(partition_full_flag)
        |-> since_rise inside {[4'h2:4'h6]}) else $error("full flag off write edge");
    a_no_empty_store: assert property (rd_valid |-> rd_entry.mask != 4'h0)
        else $error("empty word stored");
    a_valid_after_req: assert property (rd_valid |-> $past(rd_req) || $past(rd_req, 2)
        || $past(rd_req, 3)) else $error("drain without request");
    a_irq_has_cause: assert property ($rose(irq) |-> since_rise inside {[4'h2:4'h7]}
        || $past(reg_wr) || $past(reg_wr, 2)) else $error("irq without cause");
endmodule : txvf_port_properties
bind txvf_port txvf_port_properties u_props (.clk(clk), .srst(srst),
    .write_ref_clock(write_ref_clock), .bank_poll_disable(bank_poll_disable),
    .rd_req(rd_req), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .partition_full_flag(partition_full_flag), .rd_valid(rd_valid), .rd_entry(rd_entry));
`default_nettype wire

// ### txvf_sync.sv
`timescale 1ns/1ps
`default_nettype none
module txvf_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // meta is read by q alone
    always_ff @(posedge clk) begin
        if (srst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : txvf_sync
`default_nettype wire

// ### txvf_user.sv
`timescale 1ns/1ps
`default_nettype none
module txvf_user (
    input  wire logic          clk,
    output logic               write_ref_clock,
    output txvf_pkg::txvf_wr_t wr_in,
    output logic               write_strobe
);
    import txvf_pkg::*;
    initial begin
        write_ref_clock = 1'b0;
        wr_in = '0;
        write_strobe = 1'b0;
    end
    always #80 write_ref_clock = ~write_ref_clock;
    // inputs change mid-period so the sampled edge never races them
    task automatic send(input txvf_wr_t w, input logic we);
        @(negedge write_ref_clock);
        @(posedge clk);
        wr_in <= w;
        write_strobe <= we;
        @(negedge write_ref_clock);
        @(posedge clk);
        write_strobe <= 1'b0;
        wr_in.word <= ~w.word; // released data must not look valid
    endtask : send
endmodule : txvf_user
`default_nettype wire
